// ---- src/frsd_cs_lookup.sv ----
// Command-specific meaning lookup for result codes 8 to 14.
// Assumes the issued command number is held stable by the caller while the code is decoded.
`timescale 1ns/10ps
module frsd_cs_lookup (
  input wire logic [6:0] code,
  input wire logic [7:0] cmd,
  output frsd_pkg::frsd_meaning_t meaning
);
  import frsd_pkg::*;

  logic [1:0] col;

  // ----------------------------------------------------------------
  // Column from the issued command, then row from the code
  // ----------------------------------------------------------------
  always_comb begin
    col = 2'h0;
    if (cmd == FRSD_CMD_RANGE) begin
      col = 2'h1;
    end else if (cmd == FRSD_CMD_FIXED || cmd == FRSD_CMD_POLL) begin
      col = 2'h2;
    end
    meaning = FRSD_M_NONE;
    case (code)
      7'h08: meaning = (col == 2'h0) ? FRSD_M_UPD_FAIL : (col == 2'h1) ? FRSD_M_UPD_PROG : FRSD_M_NEAREST;
      7'h09: meaning = (col == 2'h0) ? FRSD_M_PROC_HIGH : (col == 2'h1) ? FRSD_M_LRV_HIGH : FRSD_M_NOT_FIXED;
      7'h0a: meaning = (col == 2'h0) ? FRSD_M_PROC_LOW : (col == 2'h1) ? FRSD_M_LRV_LOW : FRSD_M_NO_MDROP;
      7'h0b: meaning = (col == 2'h0) ? FRSD_M_INV_VAR : (col == 2'h1) ? FRSD_M_URV_HIGH : FRSD_M_IN_MDROP;
      7'h0c: meaning = (col == 2'h1) ? FRSD_M_URV_LOW : FRSD_M_INV_UNIT;
      7'h0d: meaning = FRSD_M_BOTH_RANGE;
      7'h0e: meaning = (col == 2'h1) ? FRSD_M_SPAN_SMALL : FRSD_M_URV_PUSHED;
      default: meaning = FRSD_M_NONE;
    endcase
  end

endmodule : frsd_cs_lookup

// ---- src/frsd_decoder.sv ----
// Field reply status decoder: captures the two leading status bytes of each reply,
// classifies them, and exposes results on ports and over an APB register slave.
// Assumes the link receiver runs on clk and pulses rx_valid with both bytes present.
//
// Operation
// - First byte bit 7 set means communication failure; report its error bits.
// - Bit 7 clear means bits 6..0 form one enumerated command result code.
// - Code 5 means too few data bytes were received for the command.
// - Codes 8-15 are command-specific; 16 access restricted, 32 busy, 64 not implemented.
// - Codes 8-14 take their meaning from the issued command number.
// - In a command result, second byte holds transmitter condition flags.
// - Several condition flags may be set together; single-flag values need exactly one.
// - Revision field splits into five-bit hardware revision and three-bit signalling code.
// - Unmarked fields are unsigned integers of one, two or three bytes.
`timescale 1ns/10ps
module frsd_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire frsd_pkg::frsd_status_t rx_status,
  output frsd_pkg::frsd_decode_t dec,
  output frsd_pkg::frsd_cond_t cond,
  output logic reply_seen,
  output logic irq
);
  import frsd_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic frsd_result_t frsd_classify(input logic [6:0] code);
    frsd_result_t r;
    r = FRSD_R_UNKNOWN;
    if (code == FRSD_C_OK) begin
      r = FRSD_R_OK;
    end else if (code == FRSD_C_UNDEF) begin
      r = FRSD_R_UNDEF;
    end else if (code == FRSD_C_INV_SEL) begin
      r = FRSD_R_INV_SEL;
    end else if (code == FRSD_C_TOO_LARGE) begin
      r = FRSD_R_TOO_LARGE;
    end else if (code == FRSD_C_TOO_SMALL) begin
      r = FRSD_R_TOO_SMALL;
    end else if (code == FRSD_C_TOO_FEW) begin
      r = FRSD_R_TOO_FEW;
    end else if (code == FRSD_C_XMTR) begin
      r = FRSD_R_XMTR;
    end else if (code == FRSD_C_WPROT) begin
      r = FRSD_R_WPROT;
    end else if (code >= FRSD_C_CS_LO && code <= FRSD_C_CS_HI) begin
      r = FRSD_R_CMD_SPEC;
    end else if (code == FRSD_C_ACCESS) begin
      r = FRSD_R_ACCESS;
    end else if (code == FRSD_C_BUSY) begin
      r = FRSD_R_BUSY;
    end else if (code == FRSD_C_NOT_IMPL) begin
      r = FRSD_R_NOT_IMPL;
    end
    return r;
  endfunction : frsd_classify

  function automatic logic [3:0] frsd_popcount(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : frsd_popcount

  function automatic logic frsd_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : frsd_hit

  // ----------------------------------------------------------------
  // Combinational reply decode
  // ----------------------------------------------------------------
  frsd_decode_t dec_now;
  frsd_cond_t cond_now;
  frsd_meaning_t cs_meaning;
  logic [3:0] cond_cnt;
  logic [7:0] cmd_r;

  frsd_cs_lookup u_cs_lookup (
    .code(rx_status.first[6:0]),
    .cmd(cmd_r),
    .meaning(cs_meaning)
  );

  always_comb begin
    dec_now = '0;
    cond_now = '0;
    cond_cnt = 4'h0;
    dec_now.comm_fail = rx_status.first[FRSD_B_COMM];
    if (rx_status.first[FRSD_B_COMM]) begin
      // Bits 2 and 0 are left out on purpose
      dec_now.parity = rx_status.first[FRSD_B_PARITY];
      dec_now.overrun = rx_status.first[FRSD_B_OVERRUN];
      dec_now.framing = rx_status.first[FRSD_B_FRAMING];
      dec_now.checksum = rx_status.first[FRSD_B_CHECKSUM];
      dec_now.rx_ovf = rx_status.first[FRSD_B_RXOVF];
      dec_now.second_nz = |rx_status.second;
      dec_now.result = FRSD_R_COMMFAIL;
      dec_now.meaning = FRSD_M_NONE;
    end else begin
      dec_now.code = rx_status.first[6:0];
      dec_now.result = frsd_classify(rx_status.first[6:0]);
      dec_now.cmd_spec = (dec_now.result == FRSD_R_CMD_SPEC);
      dec_now.meaning = cs_meaning;
      cond_now.flags = rx_status.second & FRSD_COND_MASK;
      cond_cnt = frsd_popcount(cond_now.flags);
      cond_now.multi = cond_cnt > 4'h1;
      cond_now.single = cond_cnt == 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Captured reply
  // ----------------------------------------------------------------
  frsd_status_t raw_r;
  frsd_status_t raw_nxt;
  frsd_decode_t dec_r;
  frsd_decode_t dec_nxt;
  frsd_cond_t cond_r;
  frsd_cond_t cond_nxt;
  logic seen_r;
  logic seen_nxt;

  always_comb begin
    raw_nxt = raw_r;
    dec_nxt = dec_r;
    cond_nxt = cond_r;
    seen_nxt = seen_r;
    if (rx_valid) begin
      raw_nxt = rx_status;
      dec_nxt = dec_now;
      cond_nxt = cond_now;
      seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      raw_r <= '0;
      dec_r <= '0;
      cond_r <= '0;
      seen_r <= 1'b0;
    end else begin
      raw_r <= raw_nxt;
      dec_r <= dec_nxt;
      cond_r <= cond_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign dec = dec_r;
  assign cond = cond_r;
  assign reply_seen = seen_r;

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic wr;
  logic mapped;

  always_comb begin
    setup = psel && !penable;
    access = psel && penable;
    wr = access && pwrite;
    mapped = frsd_hit(paddr, FRSD_OFF_CMD) || frsd_hit(paddr, FRSD_OFF_RAW) ||
             frsd_hit(paddr, FRSD_OFF_DEC) || frsd_hit(paddr, FRSD_OFF_COND) ||
             frsd_hit(paddr, FRSD_OFF_EVT) || frsd_hit(paddr, FRSD_OFF_MASK) ||
             frsd_hit(paddr, FRSD_OFF_FIN) || frsd_hit(paddr, FRSD_OFF_FOUT);
  end

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // Software registers and field unpacker
  // ----------------------------------------------------------------
  logic [7:0] cmd_nxt;
  logic [FRSD_NUM_EVT-1:0] mask_r;
  logic [FRSD_NUM_EVT-1:0] mask_nxt;
  logic [25:0] fin_r;
  logic [25:0] fin_nxt;
  logic [23:0] fu_value;
  logic [4:0] fu_rev;
  logic [2:0] fu_phy;

  frsd_field_unpack u_field_unpack (
    .bytes(fin_r[23:0]),
    .ftype(fin_r[FRSD_FT_LSB+1:FRSD_FT_LSB]),
    .value(fu_value),
    .hw_rev(fu_rev),
    .phy_code(fu_phy)
  );

  always_comb begin
    cmd_nxt = cmd_r;
    mask_nxt = mask_r;
    fin_nxt = fin_r;
    if (wr && frsd_hit(paddr, FRSD_OFF_CMD)) begin
      cmd_nxt = pwdata[7:0];
    end
    if (wr && frsd_hit(paddr, FRSD_OFF_MASK)) begin
      mask_nxt = pwdata[FRSD_NUM_EVT-1:0];
    end
    if (wr && frsd_hit(paddr, FRSD_OFF_FIN)) begin
      fin_nxt = pwdata[25:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r <= 8'h00;
      mask_r <= '0;
      fin_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
      mask_r <= mask_nxt;
      fin_r <= fin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sticky events, write one to clear, set wins
  // ----------------------------------------------------------------
  logic [FRSD_NUM_EVT-1:0] evt_r;
  logic [FRSD_NUM_EVT-1:0] evt_nxt;
  logic [FRSD_NUM_EVT-1:0] evt_set;
  logic evt_clr_wr;

  always_comb begin
    evt_set = '0;
    evt_set[FRSD_E_REPLY] = rx_valid;
    evt_set[FRSD_E_COMM] = rx_valid && dec_now.comm_fail;
    evt_set[FRSD_E_CMDERR] = rx_valid && !dec_now.comm_fail && (dec_now.code != FRSD_C_OK);
    evt_set[FRSD_E_MALF] = rx_valid && cond_now.flags[FRSD_B_MALF];
    evt_set[FRSD_E_SECNZ] = rx_valid && dec_now.second_nz;
    evt_clr_wr = wr && frsd_hit(paddr, FRSD_OFF_EVT);
  end

  genvar gi;
  generate
    for (gi = 0; gi < FRSD_NUM_EVT; gi++) begin : g_evt
      always_comb begin
        evt_nxt[gi] = (evt_r[gi] && !(evt_clr_wr && pwdata[gi])) || evt_set[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_r <= '0;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  assign irq = |(evt_r & mask_r);

  // ----------------------------------------------------------------
  // Read data, loaded in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  always_comb begin
    prdata_nxt = prdata_r;
    if (setup) begin
      prdata_nxt = 32'h00000000;
      case (paddr)
        FRSD_OFF_CMD: prdata_nxt = {24'h000000, cmd_r};
        FRSD_OFF_RAW: prdata_nxt = {15'h0000, seen_r, raw_r};
        FRSD_OFF_DEC: prdata_nxt = {8'h00, dec_r};
        FRSD_OFF_COND: prdata_nxt = {22'h000000, cond_r};
        FRSD_OFF_EVT: prdata_nxt = {{(32-FRSD_NUM_EVT){1'b0}}, evt_r};
        FRSD_OFF_MASK: prdata_nxt = {{(32-FRSD_NUM_EVT){1'b0}}, mask_r};
        FRSD_OFF_FIN: prdata_nxt = {6'h00, fin_r};
        FRSD_OFF_FOUT: prdata_nxt = {fu_rev, fu_phy, fu_value};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h00000000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

endmodule : frsd_decoder

// ---- src/frsd_field_unpack.sv ----
// Unpacks one reply field: plain unsigned integer of 1 to 3 bytes, or a revision byte.
// Assumes bytes arrive right-aligned, most significant byte first on the link.
`timescale 1ns/10ps
module frsd_field_unpack (
  input wire logic [23:0] bytes,
  input wire logic [1:0] ftype,
  output logic [23:0] value,
  output logic [4:0] hw_rev,
  output logic [2:0] phy_code
);
  import frsd_pkg::*;

  // ----------------------------------------------------------------
  // Width select and revision split
  // ----------------------------------------------------------------
  always_comb begin
    value = 24'h000000;
    hw_rev = 5'h00;
    phy_code = 3'h0;
    case (ftype)
      FRSD_FT_INT8: value = {16'h0000, bytes[7:0]};
      FRSD_FT_INT16: value = {8'h00, bytes[15:0]};
      FRSD_FT_INT24: value = bytes;
      FRSD_FT_REV: begin
        value = {16'h0000, bytes[7:0]};
        hw_rev = bytes[7:FRSD_REV_LSB];
        phy_code = bytes[FRSD_REV_LSB-1:0];
      end
      default: value = 24'h000000;
    endcase
  end

endmodule : frsd_field_unpack

// ---- src/frsd_pkg.sv ----
// Package for the field reply status decoder: offsets, bit positions, codes and carrier types.
// Assumes a single clock domain shared by the receiver, the decoder and the APB master.
package frsd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] FRSD_OFF_CMD = 8'h00;
  localparam logic [7:0] FRSD_OFF_RAW = 8'h04;
  localparam logic [7:0] FRSD_OFF_DEC = 8'h08;
  localparam logic [7:0] FRSD_OFF_COND = 8'h0c;
  localparam logic [7:0] FRSD_OFF_EVT = 8'h10;
  localparam logic [7:0] FRSD_OFF_MASK = 8'h14;
  localparam logic [7:0] FRSD_OFF_FIN = 8'h18;
  localparam logic [7:0] FRSD_OFF_FOUT = 8'h1c;

  // ----------------------------------------------------------------
  // First status byte
  // ----------------------------------------------------------------
  localparam int unsigned FRSD_B_COMM = 7;
  localparam int unsigned FRSD_B_PARITY = 6;
  localparam int unsigned FRSD_B_OVERRUN = 5;
  localparam int unsigned FRSD_B_FRAMING = 4;
  localparam int unsigned FRSD_B_CHECKSUM = 3;
  localparam int unsigned FRSD_B_RXOVF = 1;

  localparam logic [6:0] FRSD_C_OK = 7'h00;
  localparam logic [6:0] FRSD_C_UNDEF = 7'h01;
  localparam logic [6:0] FRSD_C_INV_SEL = 7'h02;
  localparam logic [6:0] FRSD_C_TOO_LARGE = 7'h03;
  localparam logic [6:0] FRSD_C_TOO_SMALL = 7'h04;
  localparam logic [6:0] FRSD_C_TOO_FEW = 7'h05;
  localparam logic [6:0] FRSD_C_XMTR = 7'h06;
  localparam logic [6:0] FRSD_C_WPROT = 7'h07;
  localparam logic [6:0] FRSD_C_CS_LO = 7'h08;
  localparam logic [6:0] FRSD_C_CS_HI = 7'h0f;
  localparam logic [6:0] FRSD_C_ACCESS = 7'h10;
  localparam logic [6:0] FRSD_C_BUSY = 7'h20;
  localparam logic [6:0] FRSD_C_NOT_IMPL = 7'h40;

  // ----------------------------------------------------------------
  // Second status byte (transmitter condition)
  // ----------------------------------------------------------------
  localparam int unsigned FRSD_B_MALF = 7;
  localparam int unsigned FRSD_B_CFG = 6;
  localparam int unsigned FRSD_B_COLD = 5;
  localparam int unsigned FRSD_B_FIXED = 3;
  localparam int unsigned FRSD_B_SAT = 2;
  localparam int unsigned FRSD_B_NPV = 1;
  localparam int unsigned FRSD_B_PV = 0;
  localparam logic [7:0] FRSD_COND_MASK = 8'hef;

  // ----------------------------------------------------------------
  // Command numbers that select the command-specific meaning column
  // ----------------------------------------------------------------
  localparam logic [7:0] FRSD_CMD_RANGE = 8'h23;
  localparam logic [7:0] FRSD_CMD_FIXED = 8'h28;
  localparam logic [7:0] FRSD_CMD_POLL = 8'h06;

  // ----------------------------------------------------------------
  // Field unpacking
  // ----------------------------------------------------------------
  localparam int unsigned FRSD_REV_LSB = 3;
  localparam int unsigned FRSD_FT_LSB = 24;
  localparam logic [1:0] FRSD_FT_INT8 = 2'h0;
  localparam logic [1:0] FRSD_FT_INT16 = 2'h1;
  localparam logic [1:0] FRSD_FT_INT24 = 2'h2;
  localparam logic [1:0] FRSD_FT_REV = 2'h3;

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  localparam int unsigned FRSD_NUM_EVT = 5;
  localparam int unsigned FRSD_E_REPLY = 0;
  localparam int unsigned FRSD_E_COMM = 1;
  localparam int unsigned FRSD_E_CMDERR = 2;
  localparam int unsigned FRSD_E_MALF = 3;
  localparam int unsigned FRSD_E_SECNZ = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } frsd_status_t;

  typedef enum logic [3:0] {
    FRSD_R_COMMFAIL = 4'h0, FRSD_R_OK = 4'h1, FRSD_R_UNDEF = 4'h2, FRSD_R_INV_SEL = 4'h3,
    FRSD_R_TOO_LARGE = 4'h4, FRSD_R_TOO_SMALL = 4'h5, FRSD_R_TOO_FEW = 4'h6, FRSD_R_XMTR = 4'h7,
    FRSD_R_WPROT = 4'h8, FRSD_R_CMD_SPEC = 4'h9, FRSD_R_ACCESS = 4'ha, FRSD_R_BUSY = 4'hb,
    FRSD_R_NOT_IMPL = 4'hc, FRSD_R_UNKNOWN = 4'hd
  } frsd_result_t;

  typedef enum logic [4:0] {
    FRSD_M_NONE = 5'h00, FRSD_M_UPD_FAIL = 5'h01, FRSD_M_UPD_PROG = 5'h02, FRSD_M_NEAREST = 5'h03,
    FRSD_M_PROC_HIGH = 5'h04, FRSD_M_LRV_HIGH = 5'h05, FRSD_M_NOT_FIXED = 5'h06,
    FRSD_M_PROC_LOW = 5'h07, FRSD_M_LRV_LOW = 5'h08, FRSD_M_NO_MDROP = 5'h09,
    FRSD_M_IN_MDROP = 5'h0a, FRSD_M_INV_VAR = 5'h0b, FRSD_M_URV_HIGH = 5'h0c,
    FRSD_M_INV_UNIT = 5'h0d, FRSD_M_URV_LOW = 5'h0e, FRSD_M_BOTH_RANGE = 5'h0f,
    FRSD_M_URV_PUSHED = 5'h10, FRSD_M_SPAN_SMALL = 5'h11
  } frsd_meaning_t;

  typedef struct packed {
    logic cmd_spec;
    frsd_meaning_t meaning;
    frsd_result_t result;
    logic [6:0] code;
    logic second_nz;
    logic rx_ovf;
    logic checksum;
    logic framing;
    logic overrun;
    logic parity;
    logic comm_fail;
  } frsd_decode_t;

  typedef struct packed {
    logic single;
    logic multi;
    logic [7:0] flags;
  } frsd_cond_t;

endpackage : frsd_pkg

// ---- verification/frsd_decoder_monitor.sv ----
// Concurrent checks on the decoder's reply capture and decode outputs.
// Assumes one clock domain; attached to every decoder instance by bind.
`timescale 1ns/10ps
module frsd_decoder_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire frsd_pkg::frsd_status_t rx_status,
  input wire frsd_pkg::frsd_decode_t dec,
  input wire frsd_pkg::frsd_cond_t cond,
  input wire logic reply_seen
);
  import frsd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_comm;
    rx_valid && rx_status.first[7] |=> dec.comm_fail && dec.parity == $past(rx_status.first[6]) &&
      dec.overrun == $past(rx_status.first[5]) && dec.framing == $past(rx_status.first[4]) &&
      dec.checksum == $past(rx_status.first[3]) && dec.rx_ovf == $past(rx_status.first[1]);
  endproperty
  a_comm: assert property (p_comm) else $error("failure byte bits not reported");
  property p_code;
    rx_valid && !rx_status.first[7] |=> !dec.comm_fail && dec.code == $past(rx_status.first[6:0]);
  endproperty
  a_code: assert property (p_code) else $error("result code not captured");
  property p_few;
    rx_valid && rx_status.first == 8'h05 |=> dec.result == FRSD_R_TOO_FEW;
  endproperty
  a_few: assert property (p_few) else $error("code 5 not reported as too few bytes");
  property p_spec;
    rx_valid && !rx_status.first[7] && rx_status.first[6:3] == 4'h1 |=> dec.cmd_spec && dec.result == FRSD_R_CMD_SPEC;
  endproperty
  a_spec: assert property (p_spec) else $error("codes 8 to 15 not command specific");
  property p_both;
    rx_valid && rx_status.first == 8'h0d |=> dec.meaning == FRSD_M_BOTH_RANGE;
  endproperty
  a_both: assert property (p_both) else $error("code 13 meaning wrong");
  property p_cond;
    rx_valid && !rx_status.first[7] |=> cond.flags == ($past(rx_status.second) & 8'hef);
  endproperty
  a_cond: assert property (p_cond) else $error("condition flags wrong");
  property p_multi;
    reply_seen |-> cond.multi == ($countones(cond.flags) > 1) && cond.single == ($countones(cond.flags) == 1);
  endproperty
  a_multi: assert property (p_multi) else $error("single or multi flag wrong");
  property p_hold;
    !rx_valid |=> $stable(dec) && $stable(cond);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs changed without a reply");
  property p_seen;
    rx_valid |=> reply_seen;
  endproperty
  a_seen: assert property (p_seen) else $error("reply seen not set");
  property p_fail0;
    rx_valid && rx_status.first[7] |=> dec.code == 7'h00 && cond.flags == 8'h00;
  endproperty
  a_fail0: assert property (p_fail0) else $error("failure reply leaks code or flags");
  property p_undef;
    rx_valid && rx_status.first == 8'h01 |=> dec.result == FRSD_R_UNDEF;
  endproperty
  a_undef: assert property (p_undef) else $error("code 1 not undefined");
endmodule : frsd_decoder_monitor

bind frsd_decoder frsd_decoder_monitor u_mon (
  .clk(clk),
  .rst_b(rst_b),
  .rx_valid(rx_valid),
  .rx_status(rx_status),
  .dec(dec),
  .cond(cond),
  .reply_seen(reply_seen)
);

// ---- verification/frsd_xmtr_model.sv ----
// Far-side transmitter model: hands complete two-byte replies to the decoder.
// Assumes the caller enters send just after a rising clock edge.
`timescale 1ns/10ps
module frsd_xmtr_model (
  input wire logic clk,
  output logic rx_valid,
  output frsd_pkg::frsd_status_t rx_status
);
  import frsd_pkg::*;
  initial begin
    rx_valid = 1'b0;
    rx_status = 16'hffff;
  end
  task automatic send(input logic [7:0] f, input logic [7:0] s);
    rx_valid <= 1'b1;
    rx_status <= {f, s};
    @(posedge clk);
    rx_valid <= 1'b0;
    // Lines outside a reply never repeat the last one
    rx_status <= ~{f, s};
    @(posedge clk);
  endtask : send
endmodule : frsd_xmtr_model

// ---- verification/tb_field_reply_status_decoder.sv ----
// Self-checking bench for the reply status decoder.
// Assumes the transmitter model and the bound monitor are compiled alongside.
`timescale 1ns/10ps
module tb_field_reply_status_decoder;
  import frsd_pkg::*;
  typedef struct packed {
    logic [7:0] f; logic [7:0] s; logic [7:0] cmd; logic [3:0] res; logic [4:0] mn; logic [7:0] fl; logic [5:0] lo;
  } frsd_row_t;
  localparam frsd_row_t ROWS [27] = '{
    '{8'h05, 8'h00, 8'h00, 4'h6, 5'h00, 8'h00, 6'h00}, '{8'h00, 8'h80, 8'h00, 4'h1, 5'h00, 8'h80, 6'h00},
    '{8'h00, 8'h05, 8'h00, 4'h1, 5'h00, 8'h05, 6'h00}, '{8'h00, 8'hff, 8'h00, 4'h1, 5'h00, 8'hef, 6'h00},
    '{8'h01, 8'h00, 8'h00, 4'h2, 5'h00, 8'h00, 6'h00}, '{8'h02, 8'h00, 8'h00, 4'h3, 5'h00, 8'h00, 6'h00},
    '{8'h03, 8'h00, 8'h00, 4'h4, 5'h00, 8'h00, 6'h00}, '{8'h04, 8'h00, 8'h00, 4'h5, 5'h00, 8'h00, 6'h00},
    '{8'h06, 8'h00, 8'h00, 4'h7, 5'h00, 8'h00, 6'h00}, '{8'h07, 8'h00, 8'h00, 4'h8, 5'h00, 8'h00, 6'h00},
    '{8'h10, 8'h00, 8'h00, 4'ha, 5'h00, 8'h00, 6'h00}, '{8'h20, 8'h00, 8'h00, 4'hb, 5'h00, 8'h00, 6'h00},
    '{8'h40, 8'h00, 8'h00, 4'hc, 5'h00, 8'h00, 6'h00}, '{8'h11, 8'h00, 8'h00, 4'hd, 5'h00, 8'h00, 6'h00},
    '{8'hfd, 8'h00, 8'h00, 4'h0, 5'h00, 8'h00, 6'h1f}, '{8'h82, 8'h00, 8'h00, 4'h0, 5'h00, 8'h00, 6'h21},
    '{8'h0f, 8'h00, 8'h00, 4'h9, 5'h00, 8'h00, 6'h00}, '{8'h08, 8'h00, 8'h00, 4'h9, 5'h01, 8'h00, 6'h00},
    '{8'h08, 8'h00, 8'h23, 4'h9, 5'h02, 8'h00, 6'h00}, '{8'h08, 8'h00, 8'h28, 4'h9, 5'h03, 8'h00, 6'h00},
    '{8'h09, 8'h00, 8'h23, 4'h9, 5'h05, 8'h00, 6'h00}, '{8'h0a, 8'h00, 8'h06, 4'h9, 5'h09, 8'h00, 6'h00},
    '{8'h0b, 8'h00, 8'h00, 4'h9, 5'h0b, 8'h00, 6'h00}, '{8'h0c, 8'h00, 8'h23, 4'h9, 5'h0e, 8'h00, 6'h00},
    '{8'h0d, 8'h00, 8'h28, 4'h9, 5'h0f, 8'h00, 6'h00}, '{8'h0e, 8'h00, 8'h00, 4'h9, 5'h10, 8'h00, 6'h00},
    '{8'h0e, 8'h02, 8'h23, 4'h9, 5'h11, 8'h02, 6'h00}};
  localparam logic [31:0] FIN [4] = '{32'h0012_3456, 32'h0112_3456, 32'h0212_3456, 32'h0300_00ab};
  localparam logic [31:0] FEXP [4] = '{32'h0000_0056, 32'h0000_3456, 32'h0012_3456, 32'hab00_0000};
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rx_valid, reply_seen, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  frsd_status_t rx_status;
  frsd_decode_t dec;
  frsd_cond_t cond;
  int err_count, comparisons;

  frsd_decoder DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_status(rx_status), .dec(dec), .cond(cond), .reply_seen(reply_seen), .irq(irq));
  frsd_xmtr_model u_xmtr (.clk(clk), .rx_valid(rx_valid), .rx_status(rx_status));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // The wait for the answer ends once pready is seen high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("dec", 32'h0, dec);
    chk("reply_seen", 32'h0, reply_seen);
    chk("pready idle", 32'h1, pready);
    chk("pslverr idle", 32'h0, pslverr);
    $display("test reset done");
    foreach (ROWS[i]) begin
      apb(1'b1, FRSD_OFF_CMD, {24'h0, ROWS[i].cmd});
      u_xmtr.send(ROWS[i].f, ROWS[i].s);
      chk("result", ROWS[i].res, dec.result);
      chk("meaning", ROWS[i].mn, dec.meaning);
      chk("code", ROWS[i].f[7] ? 32'h0 : ROWS[i].f[6:0], dec.code);
      chk("flags", ROWS[i].fl, cond.flags);
      chk("comm bits", ROWS[i].lo, dec[5:0]);
    end
    apb(1'b1, FRSD_OFF_CMD, 32'h0);
    chk("held meaning", 32'h11, dec.meaning);
    apb(1'b0, FRSD_OFF_CMD, 32'h0);
    chk("cmd readback", 32'h0, rd);
    $display("test table done");
    apb(1'b1, FRSD_OFF_EVT, 32'h1f);
    apb(1'b1, FRSD_OFF_MASK, 32'h02);
    chk("irq idle", 32'h0, irq);
    u_xmtr.send(8'hc7, 8'h5a);
    chk("fail low bits", 32'h63, dec[6:0]);
    chk("fail cond", 32'h0, cond);
    chk("irq set", 32'h1, irq);
    apb(1'b0, FRSD_OFF_EVT, 32'h0);
    chk("evt", 32'h13, rd);
    apb(1'b1, FRSD_OFF_EVT, 32'h02);
    chk("irq cleared", 32'h0, irq);
    apb(1'b0, FRSD_OFF_RAW, 32'h0);
    chk("raw", 32'h0001_c75a, rd);
    apb(1'b1, FRSD_OFF_MASK, 32'h0);
    u_xmtr.send(8'h00, 8'h80);
    chk("irq masked", 32'h0, irq);
    apb(1'b1, FRSD_OFF_MASK, 32'h08);
    chk("irq unmasked", 32'h1, irq);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    $display("test events done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, FRSD_OFF_FIN, FIN[i]);
      apb(1'b0, FRSD_OFF_FOUT, 32'h0);
      chk("field", FEXP[i], i < 3 ? {8'h0, rd[23:0]} : {rd[31:24], 24'h0});
    end
    $display("test fields done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("dec mid reset", 32'h0, dec);
    chk("irq mid reset", 32'h0, irq);
    rst_b <= 1'b1;
    @(posedge clk);
    u_xmtr.send(8'h05, 8'h00);
    chk("result after reset", FRSD_R_TOO_FEW, dec.result);
    chk("seen after reset", 32'h1, reply_seen);
    $display("test second reset done");
    give_verdict();
  end
endmodule : tb_field_reply_status_decoder
